// >>> src/key_sense.sv
// One key input's condition detector.
// Assumes the pin is synchronous to mclk_i; edges need one prior sample.
`timescale 1ns/1ps
module key_sense
  import key_wakeup_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic       ce_i,
  input  wire logic       pin_i,
  input  wire logic [2:0] sense_i,
  input  wire logic       enable_i,
  output logic            hit_o
);

  logic prev_r;
  logic primed_r;
  logic cond;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      prev_r   <= 1'b0;
      primed_r <= 1'b0;
    end else if (ce_i) begin
      prev_r   <= pin_i;
      primed_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  always_comb begin
    case (sense_i)
      SENSE_LOW:  cond = ~pin_i;
      SENSE_HIGH: cond = pin_i;
      SENSE_FALL: cond = primed_r & prev_r & ~pin_i;
      SENSE_RISE: cond = primed_r & ~prev_r & pin_i;
      SENSE_BOTH: cond = primed_r & (prev_r ^ pin_i);
      default:    cond = 1'b0;
    endcase
  end

  // Forced low while the clock enable is low
  assign hit_o = ce_i & enable_i & cond;

  chk_sense_fall: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && enable_i && sense_i == SENSE_FALL && primed_r && prev_r && !pin_i) |-> hit_o)
    else $error("falling edge not detected");

  chk_sense_level: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && enable_i && sense_i == SENSE_HIGH) |-> (hit_o == pin_i))
    else $error("high level decode wrong");

endmodule : key_sense

// >>> src/key_wakeup_input_config.sv
// Key wake-up configuration and detection for a group of key inputs.
// Assumes key pins synchronous to mclk_i and a one-cycle strobe bus.
//
// Behaviour
// - Control bit 7 picks pull-up: clear static, set dynamic.
// - Active-state field: low, high, falling, rising, both edges.
// - Control bit 0 is the key interrupt enable.
// - Reset leaves the active-state field at falling edge.
// - Reset clears every key interrupt enable.
`timescale 1ns/1ps
module key_wakeup_input_config
  import key_wakeup_pkg::*;
#(
  parameter int unsigned N_KEYS = 3
) (
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  input  wire logic              ce_i,
  input  wire logic [31:0]       addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [7:0]        rdata_o,
  input  wire logic [N_KEYS-1:0] key_pin_i,
  output logic      [N_KEYS-1:0] pullup_dynamic_o,
  output logic      [N_KEYS-1:0] key_req_o,
  output logic                   wake_o,
  output logic                   irq_o
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // Status and mask are one byte each
  if (N_KEYS < 1 || N_KEYS > DATA_W) begin : g_bad_keys
    $error("N_KEYS must be between 1 and 8");
  end

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0]        ctrl_r [N_KEYS];
  logic [N_KEYS-1:0] mask_r;
  logic [N_KEYS-1:0] status_q;
  logic [N_KEYS-1:0] hit;
  logic [N_KEYS-1:0] ctrl_sel;
  logic [N_KEYS-1:0] stat_clr;
  logic              stat_sel;
  logic              mask_sel;
  logic [7:0]        rdata_nxt;
  logic [7:0]        rdata_r;
  logic              irq_r;
  logic              wake_r;
  logic [N_KEYS-1:0] req_r;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < N_KEYS; i++) begin
      ctrl_sel[i] = (addr_i == CTRL_ADDR_BASE + 32'(i));
    end
  end

  assign stat_sel = (addr_i == STAT_ADDR);
  assign mask_sel = (addr_i == MASK_ADDR);

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // Bits 3..1 are read-only zero, so the write mask drops them.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < N_KEYS; i++) begin
        ctrl_r[i] <= CTRL_RESET;
      end
    end else if (ce_i && wr_i) begin
      for (int i = 0; i < N_KEYS; i++) begin
        if (ctrl_sel[i]) begin
          ctrl_r[i] <= wdata_i & CTRL_WMASK;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt mask
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      mask_r <= '0;
    end else if (ce_i && wr_i && mask_sel) begin
      mask_r <= wdata_i[N_KEYS-1:0];
    end
  end

  // Write one to clear
  assign stat_clr = (wr_i && stat_sel) ? wdata_i[N_KEYS-1:0] : '0;

  // ---------------------------------------------------------------
  // Per-key detection and sticky status
  // ---------------------------------------------------------------
  for (genvar g = 0; g < N_KEYS; g++) begin : g_key
    key_sense u_sense (
      .mclk_i   (mclk_i),
      .reset_i  (reset_i),
      .ce_i     (ce_i),
      .pin_i    (key_pin_i[g]),
      .sense_i  (ctrl_r[g][SENSE_HI:SENSE_LO]),
      .enable_i (ctrl_r[g][EN_BIT]),
      .hit_o    (hit[g])
    );

    sticky_bit u_stat (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .ce_i    (ce_i),
      .set_i   (hit[g]),
      .clr_i   (stat_clr[g]),
      .q_o     (status_q[g])
    );

    // Pull-up mode is a plain flop bit, straight out
    assign pullup_dynamic_o[g] = ctrl_r[g][PULLUP_BIT];
  end

  // ---------------------------------------------------------------
  // Wake-up requests
  // ---------------------------------------------------------------
  // Level modes hold the request; edge modes give a one-cycle pulse.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      req_r <= '0;
    end else if (ce_i) begin
      req_r <= hit;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      wake_r <= 1'b0;
    end else if (ce_i) begin
      wake_r <= |hit;
    end
  end

  assign key_req_o = req_r;
  assign wake_o    = wake_r;

  // ---------------------------------------------------------------
  // Interrupt output
  // ---------------------------------------------------------------
  // Registered, so it trails the status bits by one cycle
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_r <= 1'b0;
    end else if (ce_i) begin
      irq_r <= |(status_q & mask_r);
    end
  end

  assign irq_o = irq_r;

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    rdata_nxt = ZERO_BYTE;
    for (int i = 0; i < N_KEYS; i++) begin
      if (ctrl_sel[i]) begin
        rdata_nxt = ctrl_r[i];
      end
    end
    if (stat_sel) begin
      rdata_nxt = ZERO_BYTE;
      rdata_nxt[N_KEYS-1:0] = status_q;
    end
    if (mask_sel) begin
      rdata_nxt = ZERO_BYTE;
      rdata_nxt[N_KEYS-1:0] = mask_r;
    end
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_r <= ZERO_BYTE;
    end else if (ce_i) begin
      rdata_r <= rd_i ? rdata_nxt : ZERO_BYTE;
    end
  end

  assign rdata_o = rdata_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_pullup_write: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && wr_i && ctrl_sel[0]) |=> (pullup_dynamic_o[0] == $past(wdata_i[PULLUP_BIT])))
    else $error("pull-up mode not taken from write");

  chk_reset_sense: assert property (@(posedge mclk_i)
    $fell(reset_i) |-> (ctrl_r[0][SENSE_HI:SENSE_LO] == SENSE_FALL))
    else $error("active-state field not falling edge after reset");

  chk_reset_enable: assert property (@(posedge mclk_i)
    $fell(reset_i) |-> (ctrl_r[0][EN_BIT] == 1'b0 && key_req_o == '0))
    else $error("interrupt enable set after reset");

  chk_enable_gate: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && !ctrl_r[0][EN_BIT]) |=> !key_req_o[0])
    else $error("request from disabled key");

  chk_req_level: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && ctrl_r[0][EN_BIT] && ctrl_r[0][SENSE_HI:SENSE_LO] == SENSE_LOW
     && !key_pin_i[0]) |=> key_req_o[0])
    else $error("low level request missing");

  chk_irq_path: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && hit[0]) ##1 (ce_i && mask_r[0]) |=> irq_o)
    else $error("masked-in event gave no interrupt");

  chk_read_zero: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && rd_i && ctrl_sel[0]) |=> (rdata_o[3:1] == 3'h0))
    else $error("read-only bits not zero");

  chk_read_gap: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && !rd_i) |=> (rdata_o == ZERO_BYTE))
    else $error("read data outside read cycle");

  // ---------------------------------------------------------------
  // Checks: register writes and reads
  // ---------------------------------------------------------------
  chk_sense_write: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && wr_i && ctrl_sel[0])
    |=> (ctrl_r[0][SENSE_HI:SENSE_LO] == $past(wdata_i[SENSE_HI:SENSE_LO])))
    else $error("active-state field not taken from write");

  chk_enable_write: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && wr_i && ctrl_sel[0]) |=> (ctrl_r[0][EN_BIT] == $past(wdata_i[EN_BIT])))
    else $error("interrupt enable not taken from write");

  // Read-only bits must never pick up write data
  chk_ro_held: assert property (@(posedge mclk_i) disable iff (reset_i)
    ((ctrl_r[0] & ~CTRL_WMASK) == ZERO_BYTE))
    else $error("read-only control bits changed");

  chk_mask_write: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && wr_i && mask_sel) |=> (mask_r == $past(wdata_i[N_KEYS-1:0])))
    else $error("mask not taken from write");

  chk_read_ctrl: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && rd_i && ctrl_sel[0]) |=> (rdata_o == $past(ctrl_r[0])))
    else $error("control read data wrong");

  chk_read_status: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && rd_i && stat_sel) |=> (rdata_o[N_KEYS-1:0] == $past(status_q)))
    else $error("status read data wrong");

  chk_read_unmapped: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && rd_i && ctrl_sel == '0 && !stat_sel && !mask_sel) |=> (rdata_o == ZERO_BYTE))
    else $error("unmapped read not zero");

  // ---------------------------------------------------------------
  // Checks: detection, status and interrupt
  // ---------------------------------------------------------------
  chk_status_set: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && hit[0]) |=> status_q[0])
    else $error("event did not set status");

  chk_status_clear: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && wr_i && stat_sel && wdata_i[0] && !hit[0]) |=> !status_q[0])
    else $error("status bit not cleared by write");

  chk_irq_quiet: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && (status_q & mask_r) == '0) |=> !irq_o)
    else $error("interrupt with nothing unmasked pending");

  chk_wake_follows: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && hit != '0) |=> wake_o)
    else $error("wake-up missing after request");

  chk_wake_quiet: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && hit == '0) |=> !wake_o)
    else $error("wake-up without request");

  // A rising-edge request must drop after one cycle while the pin stays
  chk_rise_pulse: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && ctrl_r[0][SENSE_HI:SENSE_LO] == SENSE_RISE)
    ##1 (ce_i && ctrl_r[0][SENSE_HI:SENSE_LO] == SENSE_RISE && key_req_o[0])
    |=> !key_req_o[0])
    else $error("rising-edge request longer than one cycle");

  // ---------------------------------------------------------------
  // Checks: reset and clock enable
  // ---------------------------------------------------------------
  chk_reset_quiet: assert property (@(posedge mclk_i)
    $fell(reset_i) |-> (pullup_dynamic_o == '0 && !wake_o && !irq_o && rdata_o == ZERO_BYTE
                        && mask_r == '0 && status_q == '0))
    else $error("outputs or state not cleared by reset");

  // A frozen block must not move any output, whatever its inputs do
  chk_frozen_outputs: assert property (@(posedge mclk_i) disable iff (reset_i)
    !ce_i |=> ($stable(rdata_o) && $stable(key_req_o) && $stable(wake_o)
               && $stable(irq_o) && $stable(pullup_dynamic_o)))
    else $error("output moved while clock enable low");

endmodule : key_wakeup_input_config

// >>> src/key_wakeup_pkg.sv
// Constants shared by the key wake-up configuration block.
// Assumes byte-wide registers reached over a plain strobe port.
package key_wakeup_pkg;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [31:0] CTRL_ADDR_BASE = 32'hffff_f371;
  localparam logic [31:0] STAT_ADDR      = 32'hffff_f378;
  localparam logic [31:0] MASK_ADDR      = 32'hffff_f379;

  // ---------------------------------------------------------------
  // Control register layout
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned PULLUP_BIT = 7;
  localparam int unsigned SENSE_HI   = 6;
  localparam int unsigned SENSE_LO   = 4;
  localparam int unsigned EN_BIT     = 0;
  localparam logic [7:0]  CTRL_RESET = 8'h20;
  localparam logic [7:0]  CTRL_WMASK = 8'hf1;
  localparam logic [7:0]  ZERO_BYTE  = 8'h00;

  // ---------------------------------------------------------------
  // Active-state codes
  // ---------------------------------------------------------------
  localparam logic [2:0] SENSE_LOW  = 3'h0;
  localparam logic [2:0] SENSE_HIGH = 3'h1;
  localparam logic [2:0] SENSE_FALL = 3'h2;
  localparam logic [2:0] SENSE_RISE = 3'h3;
  localparam logic [2:0] SENSE_BOTH = 3'h4;

  localparam logic PULLUP_STATIC  = 1'b0;
  localparam logic PULLUP_DYNAMIC = 1'b1;

endpackage : key_wakeup_pkg

// >>> src/sticky_bit.sv
// One sticky status flag, set by hardware, cleared by software.
// Assumes set and clear come from the same clock domain.
`timescale 1ns/1ps
module sticky_bit (
  input  wire logic mclk_i,
  input  wire logic reset_i,
  input  wire logic ce_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      q_o
);

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      q_o <= 1'b0;
    end else if (ce_i) begin
      // Set wins so an event in the clearing cycle is kept
      if (set_i) begin
        q_o <= 1'b1;
      end else if (clr_i) begin
        q_o <= 1'b0;
      end
    end
  end

  chk_set_wins: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && set_i && clr_i) |=> q_o)
    else $error("event lost during clear");

endmodule : sticky_bit

// >>> test/key_pins_model.sv
// Model of the external key contacts feeding the wake-up block.
// Assumes the bench chooses pin levels; contacts move only after clock edges.
`timescale 1ns/1ps
module key_pins_model #(
  parameter int unsigned N = 3
) (
  input  wire logic         mclk_i,
  input  wire logic [N-1:0] level_i,
  output logic      [N-1:0] key_pin_o
);
  // Registered so pins are already synchronous to mclk_i, as the block expects
  initial key_pin_o = '0;
  always @(posedge mclk_i) begin
    key_pin_o <= level_i;
  end
endmodule : key_pins_model

// >>> test/key_wakeup_input_config_test.sv
// Self-checking bench for the key wake-up configuration block.
// Assumes three keys and a strobe bus with read data one cycle later.
`timescale 1ns/1ps
module key_wakeup_input_config_test;
  import key_wakeup_pkg::*;
  logic        mclk_i, reset_i, ce_i, wr_i, rd_i, wake_o, irq_o;
  logic [31:0] addr_i;
  logic [7:0]  wdata_i, rdata_o, d;
  logic [2:0]  key_pin_i, pullup_dynamic_o, key_req_o, level, prev, exp_req;
  logic [7:0]  cfg [3];
  int          err_count, total_checks, cycles;
  int          seed = 27591;

  key_wakeup_input_config key_wakeup_input_config_i (
    .mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .key_pin_i(key_pin_i), .pullup_dynamic_o(pullup_dynamic_o),
    .key_req_o(key_req_o), .wake_o(wake_o), .irq_o(irq_o));
  key_pins_model key_pins_model_i (
    .mclk_i(mclk_i), .level_i(level), .key_pin_o(key_pin_i));

  // ---------------------------------------------------------------
  // Reference and compares
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [2:0] s, input logic p, input logic q);
    case (s)
      3'h0:    hit = !p;
      3'h1:    hit = p;
      3'h2:    hit = q & !p;
      3'h3:    hit = !q & p;
      3'h4:    hit = q ^ p;
      default: hit = 1'b0;
    endcase
  endfunction : hit

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_byte

  task automatic chk_bits(input logic [2:0] g, input logic [2:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_bits

  task automatic wr(input logic [31:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    // Model copy moves on the edge that takes the write, and only if taken
    if (ce_i && a - CTRL_ADDR_BASE < 32'h3) cfg[a - CTRL_ADDR_BASE] <= v & CTRL_WMASK;
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    chk_byte(rdata_o, e);
  endtask : rd

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // History and requests advance only with the clock enable, as in the block
  always @(posedge mclk_i) begin
    if (ce_i) begin
      for (int k = 0; k < 3; k++) begin
        exp_req[k] <= cfg[k][0] & hit(cfg[k][6:4], key_pin_i[k], prev[k]);
      end
      prev <= key_pin_i;
    end
  end

  always @(negedge mclk_i) begin
    if (!reset_i && cycles > 40) begin
      chk_bits(key_req_o, exp_req);
      chk_bits({2'h0, wake_o}, {2'h0, |exp_req});
      chk_bits(pullup_dynamic_o, {cfg[2][7], cfg[1][7], cfg[0][7]});
    end
  end

  // ---------------------------------------------------------------
  // Clock, timeout and main sequence
  // ---------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      end_of_test();
    end
  end

  initial begin
    reset_i = 1'b1;
    ce_i = 1'b1;
    addr_i = '0;
    wdata_i = '0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    level = '0;
    for (int k = 0; k < 3; k++) cfg[k] = 8'h20;
    repeat (12) @(posedge mclk_i);
    reset_i <= 1'b0;
    for (int k = 0; k < 3; k++) rd(CTRL_ADDR_BASE + k, 8'h20);
    rd(CTRL_ADDR_BASE + 3, 8'h00);
    chk_bits(pullup_dynamic_o, 3'h0);
    $display("test reset_values done");
    for (int k = 0; k < 3; k++) begin
      wr(CTRL_ADDR_BASE + k, 8'hff);
      rd(CTRL_ADDR_BASE + k, 8'hf1);
    end
    $display("test register_access done");
    // Every sense code, including the undefined ones, with random pins
    for (int c = 0; c < 8; c++) begin
      for (int k = 0; k < 3; k++) begin
        d = $random(seed);
        d[6:4] = c[2:0];
        wr(CTRL_ADDR_BASE + k, d);
      end
      repeat (40) begin
        @(posedge mclk_i);
        level <= $random(seed);
      end
    end
    $display("test sense_codes done");
    @(posedge mclk_i);
    level <= '0;
    for (int k = 0; k < 3; k++) wr(CTRL_ADDR_BASE + k, 8'h00);
    wr(STAT_ADDR, 8'h07);
    rd(STAT_ADDR, 8'h00);
    wr(MASK_ADDR, 8'h00);
    wr(CTRL_ADDR_BASE, 8'h11);
    @(posedge mclk_i);
    level <= 3'h1;
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    chk_bits({2'h0, irq_o}, 3'h0);
    rd(STAT_ADDR, 8'h01);
    wr(MASK_ADDR, 8'h01);
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    chk_bits({2'h0, irq_o}, 3'h1);
    level <= '0;
    repeat (4) @(posedge mclk_i);
    wr(STAT_ADDR, 8'h01);
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    chk_bits({2'h0, irq_o}, 3'h0);
    rd(STAT_ADDR, 8'h00);
    $display("test interrupt done");
    // Freeze: pins and a write move while the clock enable is low
    wr(CTRL_ADDR_BASE, 8'h01);
    repeat (2) @(posedge mclk_i);
    ce_i <= 1'b0;
    level <= 3'h1;
    wr(CTRL_ADDR_BASE, 8'h81);
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    chk_bits({2'h0, irq_o}, 3'h1);
    @(posedge mclk_i);
    ce_i <= 1'b1;
    rd(CTRL_ADDR_BASE, 8'h01);
    rd(STAT_ADDR, 8'h01);
    $display("test clock_enable done");
    // Reset in mid-run must bring back every default
    @(posedge mclk_i);
    reset_i <= 1'b1;
    for (int k = 0; k < 3; k++) cfg[k] <= CTRL_RESET;
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    for (int k = 0; k < 3; k++) rd(CTRL_ADDR_BASE + k, 8'h20);
    rd(STAT_ADDR, 8'h00);
    rd(MASK_ADDR, 8'h00);
    $display("test mid_reset done");
    end_of_test();
  end
endmodule : key_wakeup_input_config_test
